/* File: design/swd_watchdog.sv */
// Notes on behaviour
// - Trigger starts interval from last count; reads zero
// - Trigger ignored when disabled or stopped
// - Status bit shows hardware disable state
// - Action bit: reset or power-off on expiry
// - Expiry sets fired flag; write one clears
// - Fired cleared by power cycle only otherwise
// - Run bit: one running, zero stopped
// - Run from stopped waits for a trigger
// - Run written while running changes nothing
// - Ten-bit count field; zero is reserved
// - Count read returns live down-counter
// - New count waits for the next trigger
// - Eight-byte window at configurable memory base
`include "swd_regs.svh"
`default_nettype none

module swd_watchdog #(
    parameter int unsigned TICK_DIV = `SWD_TICK_CYCLES
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             power_on_reset_n,
    input  wire logic             hw_disable,
    input  wire logic [31:0]      mmio_base,
    input  wire swd_pkg::swd_req_t bus_req,
    output var  swd_pkg::swd_rsp_t bus_rsp,
    output logic                  sys_reset_req,
    output logic                  power_off_req
);
    swd_pkg::swd_state_t state_reg;
    logic                active_reg;
    logic                action_reg;
    logic                fired_reg;
    logic [9:0]          load_reg;
    logic [9:0]          cnt_reg;
    logic [31:0]         presc_reg;
    logic                hit;
    logic                wr_ctrl;
    logic                wr_cnt;
    logic                rd_ctrl;
    logic                rd_cnt;
    logic                trig_ok;
    logic                tick;
    logic                expire;

    function automatic logic in_window(input logic [31:0] a, input logic [31:0] b);
        in_window = (a - b) < `SWD_WINDOW_BYTES;
    endfunction

    // Only the two aligned words answer; others in the window are not ours
    assign hit     = bus_req.sel && in_window(bus_req.addr, mmio_base);
    assign wr_ctrl = hit && bus_req.we && (bus_req.addr[2:0] == 3'(`SWD_CTRL_OFFSET));
    assign wr_cnt  = hit && bus_req.we && (bus_req.addr[2:0] == 3'(`SWD_COUNT_OFFSET));
    assign rd_ctrl = hit && !bus_req.we && (bus_req.addr[2:0] == 3'(`SWD_CTRL_OFFSET));
    assign rd_cnt  = hit && !bus_req.we && (bus_req.addr[2:0] == 3'(`SWD_COUNT_OFFSET));

    // Trigger honoured only if already running before this write
    // A trigger that also clears run would leave a stopped interval armed
    assign trig_ok = wr_ctrl && bus_req.wdata[`SWD_BIT_TRIGGER] && bus_req.wdata[`SWD_BIT_RUN] && !hw_disable
                     && (state_reg == swd_pkg::SWD_RUNNING);
    assign tick    = (presc_reg == TICK_DIV - 1);
    assign expire  = active_reg && tick && !hw_disable && (state_reg == swd_pkg::SWD_RUNNING)
                     && (cnt_reg <= 10'h001);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg <= swd_pkg::SWD_STOPPED;
        end else if (wr_ctrl) begin
            // Writing one while running leaves state as is
            state_reg <= bus_req.wdata[`SWD_BIT_RUN] ? swd_pkg::SWD_RUNNING
                                                     : swd_pkg::SWD_STOPPED;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            action_reg <= 1'b0;
        end else if (wr_ctrl) begin
            action_reg <= bus_req.wdata[`SWD_BIT_ACTION];
        end
    end

    // Kept on the power-on reset so the flag survives a watchdog restart
    always_ff @(posedge sys_clk) begin
        if (!power_on_reset_n) begin
            fired_reg <= 1'b0;
        end else begin
            fired_reg <= expire || (fired_reg && !(wr_ctrl && bus_req.wdata[`SWD_BIT_FIRED]));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            load_reg <= `SWD_COUNT_RESET;
        end else if (wr_cnt) begin
            load_reg <= bus_req.wdata[`SWD_COUNT_MSB:`SWD_COUNT_LSB];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            presc_reg <= 32'h0000_0000;
        end else if (trig_ok || tick || hw_disable) begin
            presc_reg <= 32'h0000_0000;
        end else begin
            presc_reg <= presc_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            active_reg <= 1'b0;
            cnt_reg    <= `SWD_COUNT_RESET;
        end else if (trig_ok) begin
            active_reg <= 1'b1;
            cnt_reg    <= load_reg;
        end else if (wr_ctrl && !bus_req.wdata[`SWD_BIT_RUN]) begin
            active_reg <= 1'b0;
        end else if (expire) begin
            active_reg <= 1'b0;
            cnt_reg    <= 10'h000;
        end else if (active_reg && tick && !hw_disable && state_reg == swd_pkg::SWD_RUNNING) begin
            cnt_reg <= cnt_reg - 10'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sys_reset_req <= 1'b0;
            power_off_req <= 1'b0;
        end else begin
            sys_reset_req <= expire && !action_reg;
            power_off_req <= expire && action_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            bus_rsp <= '0;
        end else begin
            bus_rsp.rvalid <= rd_ctrl || rd_cnt;
            bus_rsp.rdata  <= 32'h0000_0000;
            if (rd_ctrl) begin
                // Trigger bit is never stored, so it reads zero
                bus_rsp.rdata[`SWD_BIT_DISABLED] <= hw_disable;
                bus_rsp.rdata[`SWD_BIT_ACTION]   <= action_reg;
                bus_rsp.rdata[`SWD_BIT_FIRED]    <= fired_reg;
                bus_rsp.rdata[`SWD_BIT_RUN]      <= (state_reg == swd_pkg::SWD_RUNNING);
            end else if (rd_cnt) begin
                bus_rsp.rdata[`SWD_COUNT_MSB:`SWD_COUNT_LSB] <= cnt_reg;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // State encoding and run bit
    AST_STATE_ONEHOT: assert property (
        state_reg == swd_pkg::SWD_STOPPED || state_reg == swd_pkg::SWD_RUNNING)
        else $error("watchdog state left its encoding");

    AST_RUN_SET: assert property (
        wr_ctrl && bus_req.wdata[`SWD_BIT_RUN]
        |=> state_reg == swd_pkg::SWD_RUNNING)
        else $error("run write did not start the watchdog");

    AST_RUN_CLEAR: assert property (
        wr_ctrl && !bus_req.wdata[`SWD_BIT_RUN]
        |=> state_reg == swd_pkg::SWD_STOPPED && !active_reg)
        else $error("stop write did not stop the watchdog");

    AST_RUN_READ: assert property (
        rd_ctrl |=> bus_rsp.rdata[`SWD_BIT_RUN] == $past(state_reg == swd_pkg::SWD_RUNNING))
        else $error("run bit misreported");

    // Action selection
    AST_ACTION_WRITE: assert property (
        wr_ctrl |=> action_reg == $past(bus_req.wdata[`SWD_BIT_ACTION]))
        else $error("action bit not stored");

    AST_ACTION_READ: assert property (
        rd_ctrl |=> bus_rsp.rdata[`SWD_BIT_ACTION] == $past(action_reg))
        else $error("action bit misreported");

    AST_REQ_EXCLUSIVE: assert property (
        !(sys_reset_req && power_off_req))
        else $error("reset and power-off requested together");

    // Fired flag
    AST_FIRED_READ: assert property (
        rd_ctrl |=> bus_rsp.rdata[`SWD_BIT_FIRED] == $past(fired_reg))
        else $error("fired flag misreported");

    AST_FIRED_CLEAR: assert property (
        wr_ctrl && bus_req.wdata[`SWD_BIT_FIRED] && !expire |=> !fired_reg)
        else $error("fired flag not cleared by a one");

    AST_FIRED_HOLD: assert property (@(posedge sys_clk) disable iff (!power_on_reset_n)
        fired_reg && !(wr_ctrl && bus_req.wdata[`SWD_BIT_FIRED]) |=> fired_reg)
        else $error("fired flag lost without a clear");

    // Register decode and read answers
    AST_RSVD_CTRL_ZERO: assert property (
        rd_ctrl |=> bus_rsp.rdata[31:8] == 24'h00_0000 && bus_rsp.rdata[6:4] == 3'h0)
        else $error("reserved control bits read as one");

    AST_RSVD_CNT_ZERO: assert property (
        rd_cnt |=> bus_rsp.rdata[31:10] == 22'h00_0000)
        else $error("reserved count bits read as one");

    AST_LOAD_WRITE: assert property (
        wr_cnt |=> load_reg == $past(bus_req.wdata[`SWD_COUNT_MSB:`SWD_COUNT_LSB]))
        else $error("count value not stored");

    AST_NO_ANSWER_OUTSIDE: assert property (
        !(rd_ctrl || rd_cnt) |=> !bus_rsp.rvalid)
        else $error("read answered outside the window");

    AST_RDATA_IDLE_ZERO: assert property (
        !(rd_ctrl || rd_cnt) |=> bus_rsp.rdata == 32'h0000_0000)
        else $error("read data not zero while idle");

    AST_MISS_NO_WRITE: assert property (
        bus_req.sel && bus_req.we && !hit
        |=> $stable(load_reg) && $stable(action_reg) && $stable(state_reg))
        else $error("write outside the window took effect");

    // Counting
    AST_DISABLED_FROZEN: assert property (
        hw_disable |=> $stable(cnt_reg))
        else $error("counter moved while disabled");

    AST_STOPPED_NO_COUNT: assert property (
        state_reg == swd_pkg::SWD_STOPPED |=> $stable(cnt_reg))
        else $error("counter moved while stopped");

    AST_NO_TICK_HOLD: assert property (
        !tick && !trig_ok |=> $stable(cnt_reg))
        else $error("counter moved between ticks");

    AST_DECREMENT: assert property (
        active_reg && tick && !hw_disable && state_reg == swd_pkg::SWD_RUNNING
        && cnt_reg > 10'h001 && !wr_ctrl |=> cnt_reg == $past(cnt_reg) - 10'h001)
        else $error("counter did not step down on a tick");

    AST_PRESC_RANGE: assert property (
        presc_reg < TICK_DIV)
        else $error("prescaler ran past its divide");

    // Expiry requests
    AST_DISABLED_NO_EXPIRY: assert property (
        hw_disable |=> !sys_reset_req && !power_off_req)
        else $error("expiry request while disabled");

    AST_REQ_NEEDS_EXPIRY: assert property (
        !expire |=> !sys_reset_req && !power_off_req)
        else $error("request without expiry");

    AST_RESET_REQ_PULSE: assert property (
        sys_reset_req |=> !sys_reset_req)
        else $error("reset request longer than one cycle");

    AST_OFF_REQ_PULSE: assert property (
        power_off_req |=> !power_off_req)
        else $error("power-off request longer than one cycle");

    AST_TRIG_LOADS: assert property (trig_ok |=> active_reg && cnt_reg == $past(load_reg))
        else $error("trigger did not load the count");
    AST_TRIG_READS_ZERO: assert property (rd_ctrl |=> bus_rsp.rvalid && !bus_rsp.rdata[7])
        else $error("trigger bit read back as one");
    AST_TRIG_IGNORED: assert property (wr_ctrl && bus_req.wdata[7] && (hw_disable ||
        state_reg == swd_pkg::SWD_STOPPED) |=> $stable(cnt_reg))
        else $error("ignored trigger changed the counter");
    AST_DIS_VISIBLE: assert property (rd_ctrl |=> bus_rsp.rdata[3] == $past(hw_disable))
        else $error("disable status misreported");
    AST_ACTION_SELECT: assert property (expire |=> (sys_reset_req != $past(action_reg)) &&
        (power_off_req == $past(action_reg)))
        else $error("wrong expiry action");
    AST_FIRED_SET: assert property (expire |=> fired_reg)
        else $error("fired flag not set on expiry");
    AST_FIRED_ONLY_BY_EXPIRY: assert property (@(posedge sys_clk) disable iff (!power_on_reset_n)
        !fired_reg && !expire |=> !fired_reg)
        else $error("fired flag set without expiry");
    AST_RUN_NO_START: assert property (wr_ctrl && state_reg == swd_pkg::SWD_STOPPED && !active_reg
        |=> !active_reg)
        else $error("interval began without trigger");
    AST_RUN_AGAIN: assert property (wr_ctrl && bus_req.wdata[0] && !bus_req.wdata[7] &&
        state_reg == swd_pkg::SWD_RUNNING && !expire |=> state_reg == swd_pkg::SWD_RUNNING &&
        active_reg == $past(active_reg))
        else $error("run write disturbed a running watchdog");
    AST_LIVE_READ: assert property (rd_cnt |=> bus_rsp.rdata[9:0] == $past(cnt_reg))
        else $error("count read not live");
    AST_COUNT_WAITS: assert property (wr_cnt && !trig_ok |=> cnt_reg == $past(cnt_reg) ||
        cnt_reg == $past(cnt_reg) - 10'h001 || cnt_reg == 10'h000)
        else $error("count write disturbed the counter");
    AST_EXPIRY_FIRES: assert property (active_reg && tick && !hw_disable && cnt_reg == 10'h001 &&
        state_reg == swd_pkg::SWD_RUNNING && !trig_ok |=> !active_reg ##1 1)
        else $error("counter reached zero without firing");
endmodule
`default_nettype wire

/* File: design/swd_regs.svh */
`ifndef SWD_REGS_SVH
`define SWD_REGS_SVH

`define SWD_CTRL_OFFSET     8'h00
`define SWD_COUNT_OFFSET    8'h04
`define SWD_WINDOW_BYTES    32'h0000_0008
`define SWD_BIT_TRIGGER     7
`define SWD_BIT_DISABLED    3
`define SWD_BIT_ACTION      2
`define SWD_BIT_FIRED       1
`define SWD_BIT_RUN         0
`define SWD_COUNT_LSB       0
`define SWD_COUNT_MSB       9
`define SWD_COUNT_RESET     10'h000
`define SWD_CLK_PERIOD_NS   5
`define SWD_TICK_PERIOD_NS  1000
`define SWD_TICK_CYCLES     ((`SWD_TICK_PERIOD_NS + `SWD_CLK_PERIOD_NS - 1) / `SWD_CLK_PERIOD_NS)

`endif

/* File: design/swd_pkg.sv */
`default_nettype none
package swd_pkg;
    typedef struct packed {
        logic        sel;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } swd_req_t;

    typedef struct packed {
        logic        rvalid;
        logic [31:0] rdata;
    } swd_rsp_t;

    typedef enum logic [1:0] {
        SWD_STOPPED = 2'b01,
        SWD_RUNNING = 2'b10
    } swd_state_t;
endpackage
`default_nettype wire

/* File: testbench/tb_system_watchdog_timer.sv */
`default_nettype none
module tb_system_watchdog_timer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TDIV = 4;
    logic              sys_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              power_on_reset_n = 1'b0;
    logic              hw_disable = 1'b0;
    logic [31:0]       base = 32'h0;
    logic [31:0]       seed = 32'hF89A9099;
    logic [31:0]       v;
    swd_pkg::swd_req_t req = '0;
    swd_pkg::swd_rsp_t rsp;
    logic              rst_req;
    logic              off_req;
    int                bad_count = 0;
    int                check_count = 0;
    int                cyc = 0;
    int                t0;
    int                old;
    // Reference model state
    int                m_run = 0, m_act = 0, m_fired = 0, m_load = 0, m_cnt = 0;
    int                exp_q[$];

    swd_watchdog #(.TICK_DIV(TDIV)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .power_on_reset_n(power_on_reset_n), .hw_disable(hw_disable), .mmio_base(base),
        .bus_req(req), .bus_rsp(rsp), .sys_reset_req(rst_req), .power_off_req(off_req));

    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [31:0] ctrl_exp();
        return {28'h0, hw_disable, m_act[0], m_fired[0], m_run[0]};
    endfunction

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task stop_test();
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Returns one ns after the taking edge so callers see a settled timeline
    task wr(input logic [31:0] off, input logic [31:0] data);
        @(posedge sys_clk) req <= '{1'b1, 1'b1, base + off, data};
        @(posedge sys_clk) req.sel <= 1'b0;
        #1;
        if (off == 32'h4) m_load = int'(data[9:0]);
        else begin
            if (data[7] && m_run == 1 && data[0] && !hw_disable) begin
                m_cnt = m_load;
                exp_q.push_back(int'(data[2]));
            end
            if (data[1]) m_fired = 0;
            m_act = int'(data[2]);
            m_run = int'(data[0]);
        end
    endtask

    task rd(input logic [31:0] off, input logic vld, output logic [31:0] val);
        @(posedge sys_clk) req <= '{1'b1, 1'b0, base + off, 32'h0};
        @(posedge sys_clk) req.sel <= 1'b0;
        #1;
        val = rsp.rdata;
        chk("rvalid", {31'h0, rsp.rvalid}, {31'h0, vld});
    endtask

    task wait_expiry(input int load);
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge sys_clk) #1;
            if (rst_req === 1'b1 || off_req === 1'b1) break;
        end
        if (i == 300) begin
            bad_count++;
            stop_test();
        end
        chk("expiry_time", 32'(cyc - t0 >= load * TDIV - 1 && cyc - t0 <= load * TDIV + 2), 1);
        chk("power_off_req", {31'h0, off_req}, 32'(exp_q[0]));
        chk("sys_reset_req", {31'h0, rst_req}, 32'(exp_q.pop_front() == 0));
        m_fired = 1;
        rd(0, 1'b1, v);
        chk("ctrl_fired", v, ctrl_exp());
    endtask

    initial begin
        base = xs() & 32'hFFFF_FFF0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        power_on_reset_n <= 1'b1;
        rd(0, 1'b1, v);
        chk("ctrl_reset", v, ctrl_exp());
        rd(4, 1'b1, v);
        chk("count_reset", v, 32'h0);
        wr(4, 32'(2 + xs() % 6));
        wr(0, 32'h80);
        rd(4, 1'b1, v);
        chk("count_trig_stopped", v, 32'h0);
        wr(0, 32'h01);
        rd(4, 1'b1, v);
        chk("count_run_only", v, 32'h0);
        wr(0, 32'h81);
        t0 = cyc;
        old = m_load;
        rd(4, 1'b1, v);
        chk("count_live", v, 32'(m_cnt));
        wr(4, 32'h3FF);
        wr(0, 32'h01);
        wait_expiry(old);
        $display("Test reset expiry done");
        wr(0, 32'h01);
        rd(0, 1'b1, v);
        chk("fired_w0", v, ctrl_exp());
        wr(0, 32'h03);
        rd(0, 1'b1, v);
        chk("fired_w1c", v, ctrl_exp());
        wr(4, 32'(2 + xs() % 6));
        wr(0, 32'h05);
        wr(0, 32'h85);
        t0 = cyc;
        wait_expiry(m_load);
        $display("Test power off expiry done");
        @(posedge sys_clk) reset_n <= 1'b0;
        @(posedge sys_clk) reset_n <= 1'b1;
        m_run = 0;
        m_act = 0;
        rd(0, 1'b1, v);
        chk("fired_after_restart", v, ctrl_exp());
        @(posedge sys_clk) power_on_reset_n <= 1'b0;
        @(posedge sys_clk) power_on_reset_n <= 1'b1;
        m_fired = 0;
        rd(0, 1'b1, v);
        chk("fired_after_power", v, ctrl_exp());
        @(posedge sys_clk) hw_disable <= 1'b1;
        wr(0, 32'h01);
        wr(0, 32'h81);
        rd(0, 1'b1, v);
        chk("ctrl_disabled", v, ctrl_exp());
        rd(4, 1'b1, v);
        chk("count_disabled", v, 32'h0);
        rd(8, 1'b0, v);
        $display("Test disable and decode done");
        stop_test();
    end
endmodule
`default_nettype wire
